/* common/btc_pkg.sv */
package btc_pkg;

  // ==========================================================
  // Register locations
  localparam logic [7:0] ADDR_SECOND_COUNT   = 8'h04;
  localparam logic [7:0] ADDR_MINUTE_COUNT   = 8'h05;
  localparam logic [7:0] ADDR_HOUR_COUNT     = 8'h06;
  localparam logic [7:0] ADDR_DAY_COUNT      = 8'h07;
  localparam logic [7:0] ADDR_WEEKDAY_COUNT  = 8'h08;
  localparam logic [7:0] ADDR_MONTH_COUNT    = 8'h09;
  localparam logic [7:0] ADDR_YEAR_COUNT     = 8'h0A;

  // ==========================================================
  // Field positions and masks
  localparam int         OSC_HALT_BIT        = 7;
  localparam int         MERIDIEM_BIT        = 5;
  localparam logic [7:0] SECOND_MASK         = 8'h7F;
  localparam logic [7:0] MINUTE_MASK         = 8'h7F;
  localparam logic [7:0] HOUR24_MASK         = 8'h3F;
  localparam logic [7:0] HOUR12_MASK         = 8'h1F;
  localparam logic [7:0] DAY_MASK            = 8'h3F;
  localparam logic [7:0] WEEKDAY_MASK        = 8'h07;
  localparam logic [7:0] MONTH_MASK          = 8'h1F;
  localparam logic [7:0] YEAR_MASK           = 8'hFF;

  // ==========================================================
  // Reset values
  localparam logic       OSC_HALT_RESET      = 1'b1;
  localparam logic [7:0] SECOND_RESET        = 8'h00;
  localparam logic [7:0] MINUTE_RESET        = 8'h00;
  localparam logic [7:0] HOUR_RESET          = 8'h00;
  localparam logic [7:0] DAY_RESET           = 8'h01;
  localparam logic [7:0] WEEKDAY_RESET       = 8'h06;
  localparam logic [7:0] MONTH_RESET         = 8'h01;
  localparam logic [7:0] YEAR_RESET          = 8'h00;

  // ==========================================================
  // Counting limits (BCD)
  localparam logic [7:0] SIXTY_TOP           = 8'h59;
  localparam logic [7:0] HOUR24_TOP          = 8'h23;
  localparam logic [7:0] HOUR12_NOON         = 8'h12;
  localparam logic [7:0] HOUR12_ELEVEN       = 8'h11;
  localparam logic [7:0] WEEKDAY_TOP         = 8'h06;
  localparam logic [7:0] MONTH_TOP           = 8'h12;
  localparam logic [7:0] MONTH_FEB           = 8'h02;
  localparam logic [7:0] YEAR_TOP            = 8'h99;
  localparam logic [7:0] BCD_ZERO            = 8'h00;
  localparam logic [7:0] BCD_ONE             = 8'h01;
  localparam logic [7:0] DAYS_28             = 8'h28;
  localparam logic [7:0] DAYS_29             = 8'h29;
  localparam logic [7:0] DAYS_30             = 8'h30;
  localparam logic [7:0] DAYS_31             = 8'h31;

  // ==========================================================
  // Time and calendar counters
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] wday;
    logic [7:0] mon;
    logic [7:0] year;
  } btc_time_type;

  // Byte register port from the serial engine
  typedef struct packed {
    logic       active;
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } btc_regreq_type;

endpackage : btc_pkg

/* rtl/btc_osc_monitor.sv */
module btc_osc_monitor (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Raw inputs from the oscillator domain
  input  wire logic oscRunningIn,
  input  wire logic tickIn,
  // Synchronised results
  output logic      oscStopped,
  output logic      tickPulse
);

  // ==========================================================
  // Two-stage synchronisers
  logic runMeta_r;
  logic runSync_r;
  logic tickMeta_r;
  logic tickSync_r;
  logic tickPrev_r;

  // Running reads low at reset, so the start-up interval counts as stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      runMeta_r <= 1'b0;
      runSync_r <= 1'b0;
    end else begin
      runMeta_r <= oscRunningIn;
      runSync_r <= runMeta_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickMeta_r <= 1'b0;
      tickSync_r <= 1'b0;
      tickPrev_r <= 1'b0;
    end else begin
      tickMeta_r <= tickIn;
      tickSync_r <= tickMeta_r;
      tickPrev_r <= tickSync_r;
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oscStopped <= 1'b1;
      tickPulse  <= 1'b0;
    end else begin
      oscStopped <= !runSync_r;
      tickPulse  <= tickSync_r && !tickPrev_r;
    end
  end

endmodule : btc_osc_monitor

/* rtl/btc_time_counters.sv */
// Functional notes
// - Seconds are BCD, tens in bits 6..4, units 3..0, 00..59, reset 00.
// - Halt flag sets whenever the crystal oscillator stops for any reason.
// - Oscillator counts as stopped from power-on until stable resonance.
// - Halt flag stays set until the host writes to clear it.
// - Host clear fails while the oscillator is not running.
// - Minutes BCD, tens bits 6..4, units 3..0, bit 7 reads 0, reset 00.
// - 12-hour hours: bit 5 meridiem, bit 4 tens, bits 3..0 units.
// - 24-hour hours: tens bits 5..4, units 3..0, bits 7..6 read 0.
// - Hour format comes from the hour-format select control bit.
// - Day of month BCD, tens 5..4, units 3..0, upper bits 0, reset 01.
// - Year divisible by four, including 00, gives February a 29th day.
// - Weekday is three bits 0..6, bits 7..3 read zero.
// - Weekday counts 0..6 cyclically, reset value 6.
// - Month BCD 01..12, tens bit 4, units 3..0, upper bits 0, reset 01.
// - Year BCD 00..99, tens 7..4, units 3..0, reset 00.
// - Halt flag is bit 7 of seconds and resets to one.
// - Counters freeze during host access; one pending tick is kept.
module btc_time_counters
  import btc_pkg::*;
(
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst_n,
  // Oscillator side
  input  wire logic           oscRunningIn,
  input  wire logic           tickIn,
  // Control
  input  wire logic           hourFormat12,
  // Register port
  input  wire btc_pkg::btc_regreq_type regReq,
  output logic [7:0]          regRdData,
  // Status
  output logic                oscHaltFlag
);

  import btc_pkg::*;

  // ==========================================================
  // Oscillator monitor
  logic oscStopped;
  logic tickPulse;

  btc_osc_monitor uMonitor (
    .clk          (clk),
    .rst_n        (rst_n),
    .oscRunningIn (oscRunningIn),
    .tickIn       (tickIn),
    .oscStopped   (oscStopped),
    .tickPulse    (tickPulse)
  );

  // ==========================================================
  // BCD helpers
  function automatic logic [7:0] bcdNext(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction : bcdNext

  // Value mod 4 is (2*tens + units) mod 4
  function automatic logic isLeap(input logic [7:0] y);
    logic [1:0] m;
    m = y[1:0] + {y[4], 1'b0};
    return (m == 2'b00);
  endfunction : isLeap

  function automatic logic [7:0] monthLast(input logic [7:0] mon,
                                           input logic       leap);
    logic [7:0] r;
    r = DAYS_31;
    case (mon)
      8'h04, 8'h06, 8'h09, 8'h11: begin
        r = DAYS_30;
      end
      MONTH_FEB: begin
        r = leap ? DAYS_29 : DAYS_28;
      end
      default: begin
        r = DAYS_31;
      end
    endcase
    return r;
  endfunction : monthLast

  // ==========================================================
  // Counter state
  btc_time_type timeCnt_r;
  btc_time_type timeCnt_nxt;
  logic         oscHalt_r;
  logic         pendTick_r;
  logic         doStep;

  // A tick inside an access waits; a second tick in the same access is lost
  assign doStep = !regReq.active && (tickPulse || pendTick_r);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pendTick_r <= 1'b0;
    end else if (regReq.active) begin
      if (tickPulse) begin
        pendTick_r <= 1'b1;
      end
    end else begin
      pendTick_r <= 1'b0;
    end
  end

  // ==========================================================
  // One-second step
  logic       carryMin;
  logic       carryHour;
  logic       carryDay;
  logic       carryMon;
  logic       carryYear;
  logic [7:0] hourNum;

  always_comb begin
    timeCnt_nxt = timeCnt_r;
    carryMin    = 1'b0;
    carryHour   = 1'b0;
    carryDay    = 1'b0;
    carryMon    = 1'b0;
    carryYear   = 1'b0;
    hourNum     = timeCnt_r.hour & HOUR12_MASK;
    // Seconds
    if (timeCnt_r.sec == SIXTY_TOP) begin
      timeCnt_nxt.sec = BCD_ZERO;
      carryMin        = 1'b1;
    end else begin
      timeCnt_nxt.sec = bcdNext(timeCnt_r.sec);
    end
    // Minutes
    if (carryMin) begin
      if (timeCnt_r.min == SIXTY_TOP) begin
        timeCnt_nxt.min = BCD_ZERO;
        carryHour       = 1'b1;
      end else begin
        timeCnt_nxt.min = bcdNext(timeCnt_r.min);
      end
    end
    // Hours
    if (carryHour) begin
      if (hourFormat12) begin
        if (hourNum == HOUR12_ELEVEN) begin
          // Meridiem flips entering 12; PM 11 to AM 12 ends the day
          timeCnt_nxt.hour = HOUR12_NOON;
          timeCnt_nxt.hour[MERIDIEM_BIT] = !timeCnt_r.hour[MERIDIEM_BIT];
          carryDay = timeCnt_r.hour[MERIDIEM_BIT];
        end else if (hourNum == HOUR12_NOON) begin
          timeCnt_nxt.hour = BCD_ONE;
          timeCnt_nxt.hour[MERIDIEM_BIT] = timeCnt_r.hour[MERIDIEM_BIT];
        end else begin
          timeCnt_nxt.hour = bcdNext(hourNum);
          timeCnt_nxt.hour[MERIDIEM_BIT] = timeCnt_r.hour[MERIDIEM_BIT];
        end
      end else if (timeCnt_r.hour == HOUR24_TOP) begin
        timeCnt_nxt.hour = BCD_ZERO;
        carryDay         = 1'b1;
      end else begin
        timeCnt_nxt.hour = bcdNext(timeCnt_r.hour) & HOUR24_MASK;
      end
    end
    // Day of month and weekday
    if (carryDay) begin
      if (timeCnt_r.wday == WEEKDAY_TOP) begin
        timeCnt_nxt.wday = BCD_ZERO;
      end else begin
        timeCnt_nxt.wday = timeCnt_r.wday + 8'h01;
      end
      if (timeCnt_r.day >= monthLast(timeCnt_r.mon,
                                     isLeap(timeCnt_r.year))) begin
        timeCnt_nxt.day = BCD_ONE;
        carryMon        = 1'b1;
      end else begin
        timeCnt_nxt.day = bcdNext(timeCnt_r.day);
      end
    end
    // Month
    if (carryMon) begin
      if (timeCnt_r.mon >= MONTH_TOP) begin
        timeCnt_nxt.mon = BCD_ONE;
        carryYear       = 1'b1;
      end else begin
        timeCnt_nxt.mon = bcdNext(timeCnt_r.mon);
      end
    end
    // Year
    if (carryYear) begin
      if (timeCnt_r.year == YEAR_TOP) begin
        timeCnt_nxt.year = BCD_ZERO;
      end else begin
        timeCnt_nxt.year = bcdNext(timeCnt_r.year);
      end
    end
  end

  // ==========================================================
  // Counter registers: host writes only land during an access
  logic wrHit;

  assign wrHit = regReq.active && regReq.wrEn;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timeCnt_r.sec  <= SECOND_RESET;
      timeCnt_r.min  <= MINUTE_RESET;
      timeCnt_r.hour <= HOUR_RESET;
      timeCnt_r.day  <= DAY_RESET;
      timeCnt_r.wday <= WEEKDAY_RESET;
      timeCnt_r.mon  <= MONTH_RESET;
      timeCnt_r.year <= YEAR_RESET;
    end else if (wrHit) begin
      case (regReq.addr)
        ADDR_SECOND_COUNT: begin
          timeCnt_r.sec <= regReq.wrData & SECOND_MASK;
        end
        ADDR_MINUTE_COUNT: begin
          timeCnt_r.min <= regReq.wrData & MINUTE_MASK;
        end
        ADDR_HOUR_COUNT: begin
          if (hourFormat12) begin
            timeCnt_r.hour <= regReq.wrData & (HOUR12_MASK | 8'h20);
          end else begin
            timeCnt_r.hour <= regReq.wrData & HOUR24_MASK;
          end
        end
        ADDR_DAY_COUNT: begin
          timeCnt_r.day <= regReq.wrData & DAY_MASK;
        end
        ADDR_WEEKDAY_COUNT: begin
          timeCnt_r.wday <= regReq.wrData & WEEKDAY_MASK;
        end
        ADDR_MONTH_COUNT: begin
          timeCnt_r.mon <= regReq.wrData & MONTH_MASK;
        end
        ADDR_YEAR_COUNT: begin
          timeCnt_r.year <= regReq.wrData & YEAR_MASK;
        end
        default: begin
          timeCnt_r <= timeCnt_r;
        end
      endcase
    end else if (doStep) begin
      timeCnt_r <= timeCnt_nxt;
    end
  end

  // ==========================================================
  // Oscillator halt flag
  logic osClearReq;
  logic osSetReq;

  assign osClearReq = wrHit && (regReq.addr == ADDR_SECOND_COUNT)
                      && !regReq.wrData[OSC_HALT_BIT];
  assign osSetReq   = wrHit && (regReq.addr == ADDR_SECOND_COUNT)
                      && regReq.wrData[OSC_HALT_BIT];

  // Stopped oscillator wins over a clear, so a dead crystal keeps it set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oscHalt_r <= OSC_HALT_RESET;
    end else if (oscStopped) begin
      oscHalt_r <= 1'b1;
    end else if (osSetReq) begin
      oscHalt_r <= 1'b1;
    end else if (osClearReq) begin
      oscHalt_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oscHaltFlag <= OSC_HALT_RESET;
    end else begin
      oscHaltFlag <= oscHalt_r;
    end
  end

  // ==========================================================
  // Read path: one cycle after the read strobe
  logic [7:0] rdMux;

  always_comb begin
    rdMux = 8'h00;
    case (regReq.addr)
      ADDR_SECOND_COUNT: begin
        rdMux = timeCnt_r.sec & SECOND_MASK;
        rdMux[OSC_HALT_BIT] = oscHalt_r;
      end
      ADDR_MINUTE_COUNT: begin
        rdMux = timeCnt_r.min & MINUTE_MASK;
      end
      ADDR_HOUR_COUNT: begin
        rdMux = timeCnt_r.hour & HOUR24_MASK;
      end
      ADDR_DAY_COUNT: begin
        rdMux = timeCnt_r.day & DAY_MASK;
      end
      ADDR_WEEKDAY_COUNT: begin
        rdMux = timeCnt_r.wday & WEEKDAY_MASK;
      end
      ADDR_MONTH_COUNT: begin
        rdMux = timeCnt_r.mon & MONTH_MASK;
      end
      ADDR_YEAR_COUNT: begin
        rdMux = timeCnt_r.year;
      end
      default: begin
        rdMux = 8'h00;
      end
    endcase
  end

  // Counters are frozen during the access, so a burst reads one moment
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regReq.active && regReq.rdEn) begin
      regRdData <= rdMux;
    end
  end

endmodule : btc_time_counters

/* sim/btc_time_counters_assertions.sv */
module btc_time_counters_assertions
  import btc_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Stimulus side
  input  wire logic                    oscRunningIn,
  input  wire logic                    tickIn,
  input  wire logic                    hourFormat12,
  input  wire btc_pkg::btc_regreq_type regReq,
  // Results
  input  wire logic [7:0]              regRdData,
  input  wire logic                    oscHaltFlag
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic rdTake;
  logic clrTake;
  assign rdTake  = regReq.active && regReq.rdEn;
  assign clrTake = regReq.active && regReq.wrEn
                   && !regReq.wrData[OSC_HALT_BIT]
                   && regReq.addr == ADDR_SECOND_COUNT;

  // ==========================================================
  // Sequences
  sequence rd_at(logic [7:0] a);
    rdTake && regReq.addr == a;
  endsequence
  // Long enough for the sync chain and output stage
  sequence osc_dead;
    (!oscRunningIn) [*6];
  endsequence

  // ==========================================================
  // Halt flag
  halt_reset_a: assert property ($rose(rst_n) |-> oscHaltFlag)
    else $error("halt flag not set after reset");
  halt_set_a: assert property ($fell(oscRunningIn) |-> ##[1:6] oscHaltFlag)
    else $error("halt flag not set after oscillator stop");
  halt_sticky_a: assert property (osc_dead |=> oscHaltFlag)
    else $error("halt flag cleared while oscillator stopped");
  halt_clear_a: assert property ($fell(oscHaltFlag) |->
      $past(clrTake, 2) || $past(clrTake, 3))
    else $error("halt flag cleared without host write");

  // ==========================================================
  // Read data
  rd_hold_a: assert property (!$past(rdTake) |-> $stable(regRdData))
    else $error("read data changed without a read");
  sec_bcd_a: assert property (rd_at(ADDR_SECOND_COUNT) |=>
      regRdData[3:0] <= 4'h9 && regRdData[6:4] <= 3'h5)
    else $error("seconds not in BCD range");
  min_bits_a: assert property (rd_at(ADDR_MINUTE_COUNT) |=> !regRdData[7])
    else $error("minutes unused bit set");
  hour_bits_a: assert property (rd_at(ADDR_HOUR_COUNT) |=>
      regRdData[7:6] == 2'h0)
    else $error("hours unused bits set");
  hour12_a: assert property (rd_at(ADDR_HOUR_COUNT) ##0 hourFormat12 |=>
      (regRdData[4] ? regRdData[3:0] <= 4'h2 : regRdData[3:0] != 4'h0))
    else $error("12-hour value out of range");
  day_bits_a: assert property (rd_at(ADDR_DAY_COUNT) |=>
      regRdData[7:6] == 2'h0 && regRdData != 8'h00)
    else $error("day of month out of range");
  wday_bits_a: assert property (rd_at(ADDR_WEEKDAY_COUNT) |=>
      regRdData <= WEEKDAY_TOP)
    else $error("weekday out of range");
  mon_bits_a: assert property (rd_at(ADDR_MONTH_COUNT) |=>
      regRdData[7:5] == 3'h0 && regRdData != 8'h00)
    else $error("month out of range");
  year_bcd_a: assert property (rd_at(ADDR_YEAR_COUNT) |=>
      regRdData[3:0] <= 4'h9 && regRdData[7:4] <= 4'h9)
    else $error("year not in BCD range");
endmodule : btc_time_counters_assertions

/* sim/btc_host_model.sv */
module btc_host_model
  import btc_pkg::*;
(
  // Clock
  input  wire logic                    clk,
  // Register port
  output btc_pkg::btc_regreq_type      regReq,
  input  wire logic [7:0]              regRdData
);
  timeunit 1ns;
  timeprecision 100ps;

  initial regReq = '0;

  task automatic acc_open();
    @(posedge clk);
    #1 regReq.active = 1'b1;
  endtask : acc_open

  task automatic acc_close();
    @(posedge clk);
    #1 regReq.active = 1'b0;
  endtask : acc_close

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    regReq.wrEn   = 1'b1;
    regReq.addr   = a;
    regReq.wrData = d;
    @(posedge clk);
    #1;
    regReq.wrEn   = 1'b0;
    // Released lines must not keep looking valid
    regReq.addr   = ~a;
    regReq.wrData = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    regReq.rdEn = 1'b1;
    regReq.addr = a;
    @(posedge clk);
    #1;
    regReq.rdEn = 1'b0;
    regReq.addr = ~a;
    d = regRdData;
  endtask : rd

  // Whole time set in one access, well inside a second
  task automatic burst_wr(input logic [55:0] v);
    acc_open();
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_SECOND_COUNT + 8'(i), v[55-8*i -: 8]);
    end
    acc_close();
  endtask : burst_wr

  task automatic burst_rd(output logic [55:0] v);
    logic [7:0] b;
    acc_open();
    for (int i = 0; i < 7; i++) begin
      rd(ADDR_SECOND_COUNT + 8'(i), b);
      v[55-8*i -: 8] = b;
    end
    acc_close();
  endtask : burst_rd
endmodule : btc_host_model

/* sim/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import btc_pkg::*;

  typedef struct packed {
    logic        mode;
    logic [55:0] start;
    logic [55:0] want;
  } btc_case_type;

  logic           clk;
  logic           rst_n;
  logic           oscRunningIn;
  logic           tickIn;
  logic           hourFormat12;
  btc_regreq_type regReq;
  logic [7:0]     regRdData;
  logic           oscHaltFlag;
  logic [55:0]    v;
  logic [7:0]     b;
  int             fails;
  int             checks;

  // Bytes: sec min hour day wday mon year
  localparam logic [55:0] RESET_TIME = 56'h80000001060100;
  localparam btc_case_type CASES [9] = '{
    '{1'b0, 56'h59592328060201, 56'h00000001000301},
    '{1'b0, 56'h59592328020200, 56'h00000029030200},
    '{1'b0, 56'h59592329030204, 56'h00000001040304},
    '{1'b0, 56'h59592331051299, 56'h00000001060100},
    '{1'b0, 56'h59592330010410, 56'h00000001020510},
    '{1'b0, 56'h09D9D2D5FEE921, 56'h10591215060921},
    '{1'b1, 56'h59591110010520, 56'h00003210010520},
    '{1'b1, 56'h59593110010520, 56'h00001211020520},
    '{1'b1, 56'h59593210010520, 56'h00002110010520}
  };

  btc_time_counters i_dut (
    .clk          (clk),
    .rst_n        (rst_n),
    .oscRunningIn (oscRunningIn),
    .tickIn       (tickIn),
    .hourFormat12 (hourFormat12),
    .regReq       (regReq),
    .regRdData    (regRdData),
    .oscHaltFlag  (oscHaltFlag)
  );

  btc_host_model i_host (
    .clk       (clk),
    .regReq    (regReq),
    .regRdData (regRdData)
  );

  // ==========================================================
  // Helpers
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  // Held high and low well past the three-cycle minimum
  task automatic tick();
    tickIn = 1'b1;
    repeat (4) @(posedge clk);
    #1 tickIn = 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask : tick

  task automatic final_report();
    $display("fails=%0d checks=%0d", fails, checks);
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // ==========================================================
  // Clock, reset, watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200000;
    fails++;
    final_report();
  end

  // ==========================================================
  // Tests
  initial begin
    fails = 0;
    checks = 0;
    rst_n = 1'b0;
    oscRunningIn = 1'b0;
    tickIn = 1'b0;
    hourFormat12 = 1'b0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    i_host.burst_rd(v);
    for (int i = 0; i < 7; i++) begin
      chk8(v[55-8*i -: 8], RESET_TIME[55-8*i -: 8]);
    end
    chk1(oscHaltFlag, 1'b1);
    // Clear refused while oscillator is still down
    i_host.burst_wr(56'h00000001060100);
    i_host.burst_rd(v);
    chk8(v[55:48], 8'h80);
    oscRunningIn = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    i_host.burst_rd(v);
    chk8(v[55:48], 8'h80);
    i_host.burst_wr(56'h00000001060100);
    i_host.burst_rd(v);
    chk8(v[55:48], 8'h00);
    chk1(oscHaltFlag, 1'b0);
    oscRunningIn = 1'b0;
    repeat (8) @(posedge clk);
    #1 oscRunningIn = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk1(oscHaltFlag, 1'b1);
    i_host.burst_wr(56'h00000001060100);
    // Carries, month lengths, leap years, field masks
    for (int c = 0; c < 9; c++) begin
      hourFormat12 = CASES[c].mode;
      i_host.burst_wr(CASES[c].start);
      tick();
      i_host.burst_rd(v);
      for (int i = 0; i < 7; i++) begin
        chk8(v[55-8*i -: 8], CASES[c].want[55-8*i -: 8]);
      end
      if (c == 5) begin
        // Two ticks during one access yield a single step
        i_host.burst_wr(56'h00000001010101);
        i_host.acc_open();
        tick();
        tick();
        i_host.rd(ADDR_SECOND_COUNT, b);
        chk8(b, 8'h00);
        i_host.acc_close();
        repeat (8) @(posedge clk);
        #1;
        i_host.burst_rd(v);
        chk8(v[55:48], 8'h01);
      end
    end
    // Outside the time block nothing is stored
    i_host.acc_open();
    i_host.wr(8'h0B, 8'h5A);
    i_host.rd(8'h0B, b);
    chk8(b, 8'h00);
    i_host.rd(8'h03, b);
    chk8(b, 8'h00);
    // Writing the halt bit as one sets it; bit 6 is kept as a seconds tens bit
    i_host.wr(ADDR_SECOND_COUNT, 8'hC5);
    i_host.rd(ADDR_SECOND_COUNT, b);
    chk8(b, 8'hC5);
    i_host.acc_close();
    chk1(oscHaltFlag, 1'b1);
    final_report();
  end
endmodule : tb_top

bind btc_time_counters btc_time_counters_assertions i_chk (
  .clk          (clk),
  .rst_n        (rst_n),
  .oscRunningIn (oscRunningIn),
  .tickIn       (tickIn),
  .hourFormat12 (hourFormat12),
  .regReq       (regReq),
  .regRdData    (regRdData),
  .oscHaltFlag  (oscHaltFlag)
);
